// ===== hdl/sps_defines.svh
// sps_defines.svh: offsets-free constants of the sleep power sequencer
// assumes: included by its bare name from the sequencer design files
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

// =====================================================================
// delay minimums, in oscillator cycles
`define SPS_T1_MIN       6'h01
`define SPS_T2_MIN       6'h0b
`define SPS_T3_MIN       6'h01
`define SPS_T4_MIN       6'h28

// =====================================================================
// clock network gate sweep, lsb to msb over three cycles
`define SPS_GATE_MASK0   16'h003f
`define SPS_GATE_MASK1   16'h07c0
`define SPS_GATE_MASK2   16'hf800
`define SPS_GATE_STEP1   2'h1
`define SPS_GATE_STEP2   2'h2

// =====================================================================
// reset values
`define SPS_GATE_RST     16'hffff
`define SPS_CNT_RST      8'h00
`define SPS_DEMO_RST     4'h0
`define SPS_TMR_RST      6'h00
`define SPS_STEP_RST     2'h0

`endif

// ===== hdl/sps_pkg.sv
// sps_pkg: types of the sleep power sequencer
// assumes: compiled before all other sequencer files
package sps_pkg;

  // =====================================================================
  // controller states, one-hot
  typedef enum logic [7:0] {
    sps_st_awake      = 8'h01,
    sps_st_enter_t1   = 8'h02,
    sps_st_enter_t2   = 8'h04,
    sps_st_enter_gate = 8'h08,
    sps_st_sleep      = 8'h10,
    sps_st_exit_t3    = 8'h20,
    sps_st_exit_gate  = 8'h40,
    sps_st_exit_t4    = 8'h80
  } sps_state_t;

  typedef logic [5:0] sps_delay_t;

endpackage

// ===== hdl/sps_timer_if.sv
// sps_timer_if: load and done handshake between controller and delay timer
// assumes: both ends on the oscillator clock
interface sps_timer_if;
  logic               load;
  sps_pkg::sps_delay_t count;
  logic               done;

  modport ctrl  (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface

// ===== hdl/sps_delay_timer.sv
// sps_delay_timer: down counter, one-cycle done pulse after a loaded delay
// assumes: loaded count is at least one; same clock as the controller
`include "sps_defines.svh"

module sps_delay_timer (
  // clock and reset
  input  wire logic  i_ref_clk,
  input  wire logic  i_rst,
  input  wire logic  i_ce,
  input  wire logic  i_srst,
  // controller side
  sps_timer_if.timer tmr
);

  sps_pkg::sps_delay_t cnt_reg;
  logic                busy_reg;
  logic                done_reg;

  assign tmr.done = done_reg;

  // =====================================================================
  // countdown
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_reg  <= `SPS_TMR_RST;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_srst)
      begin
        cnt_reg  <= `SPS_TMR_RST;
        busy_reg <= 1'b0;
        done_reg <= 1'b0;
      end
      else
      begin
        done_reg <= 1'b0;
        if (tmr.load)
        begin
          cnt_reg  <= tmr.count;
          busy_reg <= 1'b1;
        end
        else if (busy_reg)
        begin
          if (cnt_reg <= 6'h01)
          begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
          end
          else
          begin
            cnt_reg <= cnt_reg - 6'h01;
          end
        end
      end
    end
  end

endmodule // sps_delay_timer

// ===== hdl/sps_top.sv
// sps_top: sleep power sequencer with gated demo counter
// assumes: free-running oscillator clock; gate cells and i/o buffers outside
//
// Behaviour
// [R1] sleep request asserted starts the entering sequence
// [R2] after power-down, wait in sleep state
// [R3] sleep request released starts the exiting sequence
// [R4] after power-up, awake; cycle repeats on request
// [R5] requester holds request low during power-up
// [R6] indicator high at entry start, low after exit
// [R7] active-low reset_low input restores initial condition
// [R8] per-network gate control, high means clock on
// [R9] sleep drops buffer power and output enables
// [R10] demo pins tri-stated asleep, driven awake
// [R11] 8-bit free-running counter on gated network
// [R12] counter captured at entry and exit, equal
// [R13] controller runs on ungated oscillator clock always
// [R14] entry: t1 then buffers off, t2 then gating
// [R15] exit: t3 then ungating, t4 then buffers on
// [R16] sixteen gates switched lsb first within three cycles
// [R17] four six-bit delays, raised above minimums allowed
// [R18] reset: awake, gates high, buffers on, captures cleared
// [R19] sleep request synchronised before use
`include "sps_defines.svh"

module sps_top (
  // clock, enable and resets
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic        i_reset_low_n,
  // sleep request from logic or pin
  input  wire logic        i_sleep_req,
  // delay settings in cycles
  input  wire logic [5:0]  i_t1_cycles,
  input  wire logic [5:0]  i_t2_cycles,
  input  wire logic [5:0]  i_t3_cycles,
  input  wire logic [5:0]  i_t4_cycles,
  // sleep status
  output logic             o_sleep_indicator,
  output logic [7:0]       o_state,
  // clock network gates
  output logic [15:0]      o_clock_gate_vector,
  // i/o buffer power
  output logic             o_buffer_power_enable,
  output logic             o_output_driver_enable,
  // demo pins
  output logic [3:0]       o_demo_pin_out,
  output logic [3:0]       o_demo_pin_oe,
  // demo counter
  output logic [7:0]       o_counter_now,
  output logic [7:0]       o_count_at_sleep_entry,
  output logic [7:0]       o_count_at_sleep_exit
);

  // =====================================================================
  // declarations
  logic                 req_meta_reg;
  logic                 req_sync_reg;
  logic                 rstn_meta_reg;
  logic                 rstn_sync_reg;
  logic                 srst;
  sps_pkg::sps_state_t  state_reg;
  sps_pkg::sps_state_t  state_next;
  logic [1:0]           step_reg;
  logic [15:0]          gate_reg;
  logic                 buf_en_reg;
  logic                 drv_en_reg;
  logic                 ind_reg;
  logic [7:0]           cnt_reg;
  logic [7:0]           cnt_next;
  logic [7:0]           entry_reg;
  logic [7:0]           exit_reg;
  logic [3:0]           demo_reg;
  logic [3:0]           demo_oe_reg;
  sps_pkg::sps_delay_t  t1_eff;
  sps_pkg::sps_delay_t  t2_eff;
  sps_pkg::sps_delay_t  t3_eff;
  sps_pkg::sps_delay_t  t4_eff;
  logic                 gate_off_start;
  logic                 gate_on_start;
  logic                 buf_off;
  logic                 buf_on;

  sps_timer_if tmr_if ();

  // =====================================================================
  // input synchronisers
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      req_meta_reg <= i_sleep_req;  // see [R19]
      req_sync_reg <= req_meta_reg;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rstn_meta_reg <= 1'b0;
      rstn_sync_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      rstn_meta_reg <= i_reset_low_n;
      rstn_sync_reg <= rstn_meta_reg;
    end
  end

  assign srst = ~rstn_sync_reg;  // see [R7]

  // =====================================================================
  // effective delays, never below minimum
  assign t1_eff = (i_t1_cycles < `SPS_T1_MIN) ? `SPS_T1_MIN : i_t1_cycles;  // see [R17]
  assign t2_eff = (i_t2_cycles < `SPS_T2_MIN) ? `SPS_T2_MIN : i_t2_cycles;  // see [R17]
  assign t3_eff = (i_t3_cycles < `SPS_T3_MIN) ? `SPS_T3_MIN : i_t3_cycles;  // see [R17]
  assign t4_eff = (i_t4_cycles < `SPS_T4_MIN) ? `SPS_T4_MIN : i_t4_cycles;  // see [R17]

  // =====================================================================
  // next state and timer loads
  always_comb
  begin
    state_next     = state_reg;
    tmr_if.load    = 1'b0;
    tmr_if.count   = t1_eff;
    gate_off_start = 1'b0;
    gate_on_start  = 1'b0;
    buf_off        = 1'b0;
    buf_on         = 1'b0;
    unique case (state_reg)
      sps_pkg::sps_st_awake:
      begin
        if (req_sync_reg)
        begin
          state_next   = sps_pkg::sps_st_enter_t1;  // see [R1]
          tmr_if.load  = 1'b1;
          tmr_if.count = t1_eff;  // see [R14]
        end
      end
      sps_pkg::sps_st_enter_t1:
      begin
        if (tmr_if.done)
        begin
          buf_off      = 1'b1;  // see [R14]
          state_next   = sps_pkg::sps_st_enter_t2;
          tmr_if.load  = 1'b1;
          tmr_if.count = t2_eff;  // see [R14]
        end
      end
      sps_pkg::sps_st_enter_t2:
      begin
        if (tmr_if.done)
        begin
          gate_off_start = 1'b1;
          state_next     = sps_pkg::sps_st_enter_gate;
        end
      end
      sps_pkg::sps_st_enter_gate:
      begin
        if (step_reg == `SPS_GATE_STEP2)
        begin
          state_next = sps_pkg::sps_st_sleep;  // see [R2]
        end
      end
      sps_pkg::sps_st_sleep:
      begin
        if (!req_sync_reg)
        begin
          state_next   = sps_pkg::sps_st_exit_t3;  // see [R3]
          tmr_if.load  = 1'b1;
          tmr_if.count = t3_eff;  // see [R15]
        end
      end
      sps_pkg::sps_st_exit_t3:
      begin
        if (tmr_if.done)
        begin
          gate_on_start = 1'b1;  // see [R15]
          state_next    = sps_pkg::sps_st_exit_gate;
        end
      end
      sps_pkg::sps_st_exit_gate:
      begin
        if (step_reg == `SPS_GATE_STEP2)
        begin
          state_next   = sps_pkg::sps_st_exit_t4;
          tmr_if.load  = 1'b1;
          tmr_if.count = t4_eff;  // see [R15]
        end
      end
      sps_pkg::sps_st_exit_t4:
      begin
        if (tmr_if.done)
        begin
          buf_on     = 1'b1;
          state_next = sps_pkg::sps_st_awake;  // see [R4]
        end
      end
      default:
      begin
        state_next = sps_pkg::sps_st_awake;
      end
    endcase
  end

  // =====================================================================
  // delay timer
  sps_delay_timer u_delay_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_srst    (srst),
    .tmr       (tmr_if.timer)
  );

  // =====================================================================
  // state register, on the free-running oscillator
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= sps_pkg::sps_st_awake;  // see [R18]
    end
    else if (i_ce)
    begin
      if (srst)
      begin
        state_reg <= sps_pkg::sps_st_awake;  // see [R7]
      end
      else
      begin
        state_reg <= state_next;  // see [R13]
      end
    end
  end

  // =====================================================================
  // gate sweep, lsb to msb over three cycles
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      gate_reg <= `SPS_GATE_RST;  // see [R18]
      step_reg <= `SPS_STEP_RST;
    end
    else if (i_ce)
    begin
      if (srst)
      begin
        gate_reg <= `SPS_GATE_RST;
        step_reg <= `SPS_STEP_RST;
      end
      else if (gate_off_start)
      begin
        gate_reg <= gate_reg & ~`SPS_GATE_MASK0;  // see [R8] see [R16]
        step_reg <= `SPS_GATE_STEP1;
      end
      else if (gate_on_start)
      begin
        gate_reg <= gate_reg | `SPS_GATE_MASK0;  // see [R8] see [R16]
        step_reg <= `SPS_GATE_STEP1;
      end
      else if (state_reg == sps_pkg::sps_st_enter_gate)
      begin
        gate_reg <= gate_reg & ~((step_reg == `SPS_GATE_STEP1) ? `SPS_GATE_MASK1 : `SPS_GATE_MASK2);  // see [R16]
        step_reg <= (step_reg == `SPS_GATE_STEP1) ? `SPS_GATE_STEP2 : `SPS_STEP_RST;
      end
      else if (state_reg == sps_pkg::sps_st_exit_gate)
      begin
        gate_reg <= gate_reg | ((step_reg == `SPS_GATE_STEP1) ? `SPS_GATE_MASK1 : `SPS_GATE_MASK2);  // see [R16]
        step_reg <= (step_reg == `SPS_GATE_STEP1) ? `SPS_GATE_STEP2 : `SPS_STEP_RST;
      end
    end
  end

  // =====================================================================
  // buffer power and output enables
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      buf_en_reg <= 1'b1;  // see [R18]
      drv_en_reg <= 1'b1;
    end
    else if (i_ce)
    begin
      if (srst || buf_on)
      begin
        buf_en_reg <= 1'b1;  // see [R15]
        drv_en_reg <= 1'b1;
      end
      else if (buf_off)
      begin
        buf_en_reg <= 1'b0;  // see [R9]
        drv_en_reg <= 1'b0;  // see [R9]
      end
    end
  end

  // =====================================================================
  // sleep indicator
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ind_reg <= 1'b0;  // see [R18]
    end
    else if (i_ce)
    begin
      if (srst || buf_on)
      begin
        ind_reg <= 1'b0;  // see [R6]
      end
      else if (state_reg == sps_pkg::sps_st_awake && req_sync_reg)
      begin
        ind_reg <= 1'b1;  // see [R6]
      end
    end
  end

  // =====================================================================
  // demo counter on gated network 0, with captures
  assign cnt_next = gate_reg[0] ? cnt_reg + 8'h01 : cnt_reg;  // see [R11]

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_reg   <= `SPS_CNT_RST;
      entry_reg <= `SPS_CNT_RST;  // see [R18]
      exit_reg  <= `SPS_CNT_RST;
    end
    else if (i_ce)
    begin
      if (srst)
      begin
        cnt_reg   <= `SPS_CNT_RST;
        entry_reg <= `SPS_CNT_RST;
        exit_reg  <= `SPS_CNT_RST;
      end
      else
      begin
        cnt_reg <= cnt_next;  // see [R11]
        if (gate_off_start)
        begin
          entry_reg <= cnt_next;  // see [R12]
        end
        if (gate_on_start)
        begin
          exit_reg <= cnt_next;  // see [R12]
        end
      end
    end
  end

  // =====================================================================
  // demo pins follow the output driver enable
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      demo_reg    <= `SPS_DEMO_RST;
      demo_oe_reg <= 4'h0;
    end
    else if (i_ce)
    begin
      if (srst)
      begin
        demo_reg    <= `SPS_DEMO_RST;
        demo_oe_reg <= 4'h0;
      end
      else
      begin
        demo_reg    <= cnt_next[7:4];
        demo_oe_reg <= {4{drv_en_reg && !buf_off}};  // see [R10]
      end
    end
  end

  // =====================================================================
  // outputs
  assign o_sleep_indicator      = ind_reg;
  assign o_state                = state_reg;
  assign o_clock_gate_vector    = gate_reg;
  assign o_buffer_power_enable  = buf_en_reg;
  assign o_output_driver_enable = drv_en_reg;
  assign o_demo_pin_out         = demo_reg;
  assign o_demo_pin_oe          = demo_oe_reg;
  assign o_counter_now          = cnt_reg;
  assign o_count_at_sleep_entry = entry_reg;
  assign o_count_at_sleep_exit  = exit_reg;

endmodule // sps_top

// ===== test/sps_top_monitor.sv
// sps_top_monitor: concurrent checks on the sleep power sequencer ports
// assumes: bound to sps_top; one clock domain, single enable
module sps_top_monitor (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_ce,
  input wire logic        i_reset_low_n,
  input wire logic        o_sleep_indicator,
  input wire logic [7:0]  o_state,
  input wire logic [15:0] o_clock_gate_vector,
  input wire logic        o_buffer_power_enable,
  input wire logic        o_output_driver_enable,
  input wire logic [3:0]  o_demo_pin_oe,
  input wire logic [7:0]  o_counter_now,
  input wire logic [7:0]  o_count_at_sleep_entry,
  input wire logic [7:0]  o_count_at_sleep_exit
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst || !i_ce || !i_reset_low_n);

  // =====================================================================
  // properties
  property p_enter_start;
    o_state == 8'h02 |-> o_sleep_indicator && o_buffer_power_enable;
  endproperty
  a_enter_start: assert property (p_enter_start) else $error("entry start wrong");

  property p_buf_off;
    $fell(o_buffer_power_enable) |-> o_state == 8'h04 && !o_output_driver_enable;
  endproperty
  a_buf_off: assert property (p_buf_off) else $error("buffer power-down wrong");

  property p_gate_down;
    $rose(o_state == 8'h08) |-> o_clock_gate_vector == 16'hffc0 ##1 o_clock_gate_vector == 16'hf800
      ##1 (o_clock_gate_vector == 16'h0000 && o_state == 8'h10);
  endproperty
  a_gate_down: assert property (p_gate_down) else $error("gate sweep down wrong");

  property p_gate_up;
    $rose(o_state == 8'h40) |-> o_clock_gate_vector == 16'h003f ##1 o_clock_gate_vector == 16'h07ff
      ##1 (o_clock_gate_vector == 16'hffff && o_state == 8'h80);
  endproperty
  a_gate_up: assert property (p_gate_up) else $error("gate sweep up wrong");

  property p_exit_done;
    $fell(o_sleep_indicator) |-> o_state == 8'h01 && o_buffer_power_enable && o_output_driver_enable;
  endproperty
  a_exit_done: assert property (p_exit_done) else $error("exit completion wrong");

  property p_sleep_pins;
    o_state == 8'h10 |-> o_demo_pin_oe == 4'h0 && !o_buffer_power_enable && o_clock_gate_vector == 16'h0000;
  endproperty
  a_sleep_pins: assert property (p_sleep_pins) else $error("sleep outputs wrong");

  property p_freeze;
    !o_clock_gate_vector[0] |=> $stable(o_counter_now);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved while gated");

  property p_capture;
    $rose(o_state == 8'h40) |-> o_count_at_sleep_exit == o_count_at_sleep_entry;
  endproperty
  a_capture: assert property (p_capture) else $error("captures differ");

  property p_oe_back;
    $rose(o_buffer_power_enable) |-> o_demo_pin_oe == 4'h0 ##1 o_demo_pin_oe == 4'hf;
  endproperty
  a_oe_back: assert property (p_oe_back) else $error("demo enables not restored");
endmodule // sps_top_monitor

bind sps_top sps_top_monitor u_sps_top_monitor (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce), .i_reset_low_n(i_reset_low_n),
  .o_sleep_indicator(o_sleep_indicator), .o_state(o_state), .o_clock_gate_vector(o_clock_gate_vector),
  .o_buffer_power_enable(o_buffer_power_enable), .o_output_driver_enable(o_output_driver_enable),
  .o_demo_pin_oe(o_demo_pin_oe), .o_counter_now(o_counter_now),
  .o_count_at_sleep_entry(o_count_at_sleep_entry), .o_count_at_sleep_exit(o_count_at_sleep_exit));

// ===== test/sps_far_model.sv
// sps_far_model: requester and demo pads on the far side of the sequencer
// assumes: pads carry a weak pull-up when released
module sps_far_model (
  input  wire logic       i_rst,
  input  wire logic       i_want_sleep,
  input  wire logic [3:0] i_pin_out,
  input  wire logic [3:0] i_pin_oe,
  output logic            o_sleep_req,
  output logic [3:0]      o_pad
);
  timeunit 1ns;
  timeprecision 100ps;
  // request held low while the device powers up
  assign o_sleep_req = i_want_sleep & ~i_rst;
  // released pads float up to the pull-up
  always_comb
  begin
    for (int k = 0; k < 4; k++)
      o_pad[k] = i_pin_oe[k] ? i_pin_out[k] : 1'b1;
  end
endmodule // sps_far_model

// ===== test/sps_top_bench.sv
// sps_top_bench: sleep/wake sequences with cycle counts checked
// assumes: sps_top, sps_far_model and the bound monitor compiled first
module sps_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       i_ref_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic       i_ce = 1'b1;
  logic       i_reset_low_n = 1'b1;
  logic       want = 1'b0;
  logic       sleep_req;
  logic [5:0] t1 = 6'h00, t2 = 6'h00, t3 = 6'h00, t4 = 6'h00;
  logic       ind, bpe, ode;
  logic [7:0] st, cnt, c_in, c_out;
  logic [15:0] gate;
  logic [3:0] pout, poe, pad;
  int         errors = 0, compares = 0, cyc = 0, n;

  always #2.5 i_ref_clk = ~i_ref_clk;

  sps_far_model u_sps_far_model (.i_rst(i_rst), .i_want_sleep(want), .i_pin_out(pout), .i_pin_oe(poe),
    .o_sleep_req(sleep_req), .o_pad(pad));
  sps_top u_sps_top (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce), .i_reset_low_n(i_reset_low_n),
    .i_sleep_req(sleep_req), .i_t1_cycles(t1), .i_t2_cycles(t2), .i_t3_cycles(t3), .i_t4_cycles(t4),
    .o_sleep_indicator(ind), .o_state(st), .o_clock_gate_vector(gate), .o_buffer_power_enable(bpe),
    .o_output_driver_enable(ode), .o_demo_pin_out(pout), .o_demo_pin_oe(poe), .o_counter_now(cnt),
    .o_count_at_sleep_entry(c_in), .o_count_at_sleep_exit(c_out));

  // =====================================================================
  // helpers
  task automatic give_verdict();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // counts falling edges until the state shows up
  task automatic wait_st(input logic [7:0] target);
    n = 0;
    do
    begin
      @(negedge i_ref_clk);
      n++;
    end while (st !== target && n < 300);
  endtask

  task automatic full_cycle(input logic [5:0] a, b, c, d, input int ea, eb, ec, ed);
    logic [7:0] held;
    @(posedge i_ref_clk);
    {t1, t2, t3, t4} <= {a, b, c, d};
    want <= 1'b1;
    wait_st(8'h02);
    check(16'(ind), 16'h1);
    wait_st(8'h04);
    check(16'(n), 16'(ea + 1));
    check(16'({bpe, ode}), 16'h0);
    wait_st(8'h08);
    check(16'(n), 16'(eb + 1));
    check(gate, 16'hffc0);
    wait_st(8'h10);
    check(16'(n), 16'h2);
    check(gate, 16'h0000);
    check(16'(pad), 16'hf);
    held = cnt;
    repeat (10) @(negedge i_ref_clk);
    check(16'(cnt), 16'(held));
    check(16'(st), 16'h10);
    @(posedge i_ref_clk);
    want <= 1'b0;
    wait_st(8'h20);
    wait_st(8'h40);
    check(16'(n), 16'(ec + 1));
    check(gate, 16'h003f);
    wait_st(8'h80);
    check(gate, 16'hffff);
    wait_st(8'h01);
    check(16'(n), 16'(ed + 1));
    check(16'({ind, bpe, ode}), 16'h3);
    @(negedge i_ref_clk);
    check(16'(poe), 16'hf);
    check(16'(pad), 16'(cnt[7:4]));
    check(16'(c_out), 16'(c_in));
    held = cnt;
    repeat (3) @(negedge i_ref_clk);
    check(16'(cnt), 16'(8'(held + 8'h03)));
  endtask

  // =====================================================================
  // main sequence
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(negedge i_ref_clk);
    check(16'(st), 16'h01);
    check(gate, 16'hffff);
    check(16'({ind, bpe, ode}), 16'h3);
    check({c_in, c_out}, 16'h0000);
    repeat (5) @(negedge i_ref_clk);
    full_cycle(6'h00, 6'h00, 6'h00, 6'h00, 1, 11, 1, 40);
    full_cycle(6'h05, 6'h14, 6'h03, 6'h2d, 5, 20, 3, 45);
    full_cycle(6'h3f, 6'h0b, 6'h3f, 6'h28, 63, 11, 63, 40);
    // request dropped mid-entry: entry completes, then exits
    @(posedge i_ref_clk);
    want <= 1'b1;
    wait_st(8'h02);
    @(posedge i_ref_clk);
    want <= 1'b0;
    wait_st(8'h10);
    check(16'(st), 16'h10);
    wait_st(8'h20);
    check(16'(n < 4), 16'h1);
    wait_st(8'h01);
    check(16'(ind), 16'h0);
    // active-low reset in sleep returns to the initial condition
    @(posedge i_ref_clk);
    want <= 1'b1;
    wait_st(8'h10);
    @(posedge i_ref_clk);
    i_reset_low_n <= 1'b0;
    want <= 1'b0;
    repeat (5) @(negedge i_ref_clk);
    check(16'(st), 16'h01);
    check(gate, 16'hffff);
    check(16'({ind, bpe, ode}), 16'h3);
    check({c_in, c_out}, 16'h0000);
    @(posedge i_ref_clk);
    i_reset_low_n <= 1'b1;
    repeat (6) @(negedge i_ref_clk);
    full_cycle(6'h01, 6'h0c, 6'h02, 6'h29, 1, 12, 2, 41);
    give_verdict();
  end
endmodule // sps_top_bench
